/* File: adc_analog_model.sv */
/*
 * analog side model: sample-and-hold, ladder tap and comparator.
 * assumes the bench loads volt[] in ladder codes; one clock domain.
 */
`timescale 1ns/1ps

module adc_analog_model (
    input  wire logic       i_clk,
    input  wire logic       i_enable,
    input  wire logic       i_sample,
    input  wire logic       i_hold,
    input  wire logic [3:0] i_channel,
    input  wire logic [9:0] i_tap_code,
    input  wire logic       i_slow,
    output logic            o_above
);
    int   volt [16];
    int   held   = 0;
    logic slow_q = 1'b0;
    logic junk_q = 1'b0;
    logic fast;

    assign fast = (held >= int'(i_tap_code));

    always @(posedge i_clk) begin
        if (i_sample && !i_hold) begin
            held <= volt[i_channel];
        end
        slow_q <= fast;
        junk_q <= ~junk_q;
    end

    // an unpowered comparator gives no usable decision
    assign o_above = !i_enable ? junk_q : (i_slow ? slow_q : fast);
endmodule : adc_analog_model

/* File: adc_seq_defines.svh */
/*
 * register offsets, field positions, reset values and timing counts
 * of the converter sequencer. assumes one 100 MHz clock.
 */
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_MODE         3'h0
`define OFS_CHANNEL      3'h1
`define OFS_PIN_FUNC     3'h2
`define OFS_RESULT_WORD  3'h3
`define OFS_RESULT_BYTE  3'h4
`define OFS_STATUS       3'h5

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define MODE_COMP_EN_BIT 0
`define MODE_LEVEL_LSB   1
`define MODE_RATE_LSB    3
`define MODE_RUN_BIT     7
`define MODE_WR_MASK     8'hBF
`define MODE_RESET       8'h00
`define CHANNEL_RESET    4'h0
`define PIN_FUNC_RESET   4'h0
`define RESULT_WORD_RST  16'h0000
`define RESULT_BYTE_RST  8'h00
`define RESULT_LSB_ZEROS 6

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define COMP_SETTLE_NS    1000
`define SAMPLE_TICKS      8'h04
`define FIRST_EXTRA_TICKS 8'h02

`endif

/* File: adc_seq_pkg.sv */
/*
 * types shared by the converter sequencer modules.
 * assumes the defines header is compiled alongside.
 */
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

endpackage : adc_seq_pkg

/* File: sar_adc_sequencer.sv */
/*
 * converter control and successive-approximation sequencing, with
 * software registers on a plain strobe port.
 * assumes an external sample-and-hold, ladder and comparator that answer
 * i_comp_above within one clock of the trial tap changing.
 */
// Functional notes
// - mode bit 0 powers the comparator; enable it before converting.
// - mode bits 5..1 (rate and level) set the conversion time.
// - channel select bits 3..0 pick one of twelve inputs.
// - mode bit 7 set starts converting the selected channel.
// - sample for a fixed time, then hold until conversion ends.
// - first trial sets bit nine against the half tap.
// - next bit compares against three or one quarter tap.
// - continue to bit zero, then latch the ten bits.
// - raise completion pulse as the result is latched.
// - while run stays set, the next conversion starts at once.
// - channel write aborts conversion; restart from sampling if running.
// - clearing run stops at once; results keep last value.
// - reset clears word result to zero and byte result to zero.
// - word result is ten bits shifted left by six.
// - byte result updates together with the word result.
// - channel restart takes exact conversion time; first may differ.
// - config write at conversion end wins; no store, no pulse.
// - result read at conversion end returns the old value.
`timescale 1ns/1ps
`include "adc_seq_defines.svh"

module sar_adc_sequencer #(
    parameter int          RES_BITS     = 10,
    parameter logic [7:0]  SAMPLE_TICKS = `SAMPLE_TICKS,
    parameter logic [7:0]  FIRST_EXTRA  = `FIRST_EXTRA_TICKS
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_reset,
    input  wire adc_seq_pkg::reg_req_t    i_bus,
    input  wire logic                     i_comp_above,
    output logic [15:0]                   o_rdata,
    output logic                          o_conversion_done_irq,
    output logic                          o_comparator_enable,
    output logic                          o_sample,
    output logic                          o_hold,
    output logic [3:0]                    o_channel,
    output logic [9:0]                    o_tap_code
);

    // ------------------------------------------------------------------
    // constants and checks
    // ------------------------------------------------------------------
    localparam int SETTLE_INT =
        (`COMP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam logic [6:0] SETTLE_CYC = 7'(SETTLE_INT);

    generate
        if (RES_BITS != 10) begin : g_bad_res
            $error("result registers are laid out for ten bits");
        end
        if (SAMPLE_TICKS == 8'h00 || SAMPLE_TICKS > 8'h7F) begin : g_bad_smp
            $error("sample ticks must be 1 to 127");
        end
        if (FIRST_EXTRA > 8'h7F) begin : g_bad_first
            $error("first extra ticks must be below 128");
        end
    endgenerate

    typedef struct packed {
        logic [7:0]               mode;
        logic [3:0]               channel;
        logic [3:0]               pin_func;
        logic [15:0]              word;
        logic [7:0]               byte_res;
        logic [15:0]              rdata;
        logic                     irq;
        adc_seq_pkg::conv_state_t state;
        logic [7:0]               smp_cnt;
        logic [6:0]               settle;
        logic                     sample;
        logic                     hold;
    } seq_state_t;

    seq_state_t s_q;
    seq_state_t s_d;

    logic       tick;
    logic       div_restart;
    logic       sar_begin;
    logic       sar_step;
    logic       sar_done;
    logic [9:0] sar_result;
    logic [9:0] sar_trial;
    logic       conv_end;
    logic       cfg_write;
    logic       chan_write;
    logic       run_next;

    // ------------------------------------------------------------------
    // register read decode
    // ------------------------------------------------------------------
    function automatic logic [15:0] read_mux(input logic [2:0] a,
                                             input seq_state_t s);
        logic [15:0] r;
        r = 16'h0000;
        if (a == `OFS_MODE) begin
            r = {8'h00, s.mode};
        end else if (a == `OFS_CHANNEL) begin
            r = {12'h000, s.channel};
        end else if (a == `OFS_PIN_FUNC) begin
            r = {12'h000, s.pin_func};
        end else if (a == `OFS_RESULT_WORD) begin
            r = s.word;
        end else if (a == `OFS_RESULT_BYTE) begin
            r = {8'h00, s.byte_res};
        end else if (a == `OFS_STATUS) begin
            r = {14'h0000, s.settle == SETTLE_CYC,
                 s.state != adc_seq_pkg::ST_IDLE};
        end
        return r;
    endfunction : read_mux

    // ------------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------------
    step_divider u_div (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_rate    (s_q.mode[`MODE_RATE_LSB +: 3]),
        .i_level   (s_q.mode[`MODE_LEVEL_LSB +: 2]),
        .i_run     (s_q.state != adc_seq_pkg::ST_IDLE),
        .i_restart (div_restart),
        .o_tick    (tick)
    );

    sar_engine #(
        .WIDTH (10)
    ) u_sar (
        .i_clk        (i_clk),
        .i_reset      (i_reset),
        .i_begin      (sar_begin),
        .i_step       (sar_step),
        .i_comp_above (i_comp_above),
        .o_trial      (sar_trial),
        .o_result     (sar_result),
        .o_done       (sar_done)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    assign sar_step   = tick && (s_q.state == adc_seq_pkg::ST_CONVERT);
    assign conv_end   = sar_step && sar_done;
    assign chan_write = i_bus.wr && (i_bus.addr == `OFS_CHANNEL);
    assign cfg_write  = i_bus.wr && ((i_bus.addr == `OFS_MODE) ||
                        (i_bus.addr == `OFS_CHANNEL) ||
                        (i_bus.addr == `OFS_PIN_FUNC));

    always_comb begin
        s_d         = s_q;
        s_d.irq     = 1'b0;
        div_restart = 1'b0;
        sar_begin   = 1'b0;
        if (i_bus.rd) begin
            // old result is read before any store on this edge
            s_d.rdata = read_mux(i_bus.addr, s_q);
        end
        if (i_bus.wr) begin
            if (i_bus.addr == `OFS_MODE) begin
                s_d.mode = i_bus.wdata[7:0] & `MODE_WR_MASK;
            end else if (i_bus.addr == `OFS_CHANNEL) begin
                s_d.channel = i_bus.wdata[3:0];
            end else if (i_bus.addr == `OFS_PIN_FUNC) begin
                s_d.pin_func = i_bus.wdata[3:0];
            end
        end
        // comparator settling status
        if (!s_d.mode[`MODE_COMP_EN_BIT]) begin
            s_d.settle = 7'h00;
        end else if (s_q.settle != SETTLE_CYC) begin
            s_d.settle = s_q.settle + 7'h01;
        end
        if (conv_end && !cfg_write) begin
            s_d.word = {sar_result, 6'h00};
            s_d.byte_res = sar_result[9:2];
            s_d.irq = 1'b1;
        end
        run_next = s_d.mode[`MODE_RUN_BIT];
        case (s_q.state)
            adc_seq_pkg::ST_IDLE: begin
                if (run_next) begin
                    s_d.state   = adc_seq_pkg::ST_SAMPLE;
                    s_d.smp_cnt = 8'(SAMPLE_TICKS + FIRST_EXTRA);
                    div_restart = 1'b1;
                end
            end
            adc_seq_pkg::ST_SAMPLE: begin
                if (tick) begin
                    if (s_q.smp_cnt == 8'h01) begin
                        s_d.state = adc_seq_pkg::ST_CONVERT;
                        sar_begin = 1'b1;
                    end else begin
                        s_d.smp_cnt = s_q.smp_cnt - 8'h01;
                    end
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                if (conv_end) begin
                    s_d.state   = adc_seq_pkg::ST_SAMPLE;
                    s_d.smp_cnt = SAMPLE_TICKS;
                end
            end
            default: begin
                s_d.state = adc_seq_pkg::ST_IDLE;
            end
        endcase
        if (!run_next) begin
            s_d.state = adc_seq_pkg::ST_IDLE;
        end else if (chan_write && s_q.state != adc_seq_pkg::ST_IDLE) begin
            s_d.state   = adc_seq_pkg::ST_SAMPLE;
            s_d.smp_cnt = SAMPLE_TICKS;
            div_restart = 1'b1;
        end
        s_d.sample = (s_d.state == adc_seq_pkg::ST_SAMPLE);
        s_d.hold   = (s_d.state == adc_seq_pkg::ST_CONVERT);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q          <= '0;
            s_q.mode     <= `MODE_RESET;
            s_q.channel  <= `CHANNEL_RESET;
            s_q.pin_func <= `PIN_FUNC_RESET;
            s_q.word     <= `RESULT_WORD_RST;
            s_q.byte_res <= `RESULT_BYTE_RST;
            s_q.state    <= adc_seq_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata               = s_q.rdata;
    assign o_conversion_done_irq = s_q.irq;
    assign o_comparator_enable   = s_q.mode[`MODE_COMP_EN_BIT];
    assign o_sample              = s_q.sample;
    assign o_hold                = s_q.hold;
    assign o_channel             = s_q.channel;
    assign o_tap_code            = sar_trial;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_clean_end;
        conv_end && !cfg_write;
    endsequence

    sequence s_stored(logic [9:0] v);
        o_conversion_done_irq && (s_q.word == {v, 6'h00});
    endsequence

    a_store_pulse: assert property (
        s_clean_end |=> s_stored($past(sar_result)))
        else $error("result not stored with completion pulse");
    a_byte_tracks: assert property (
        s_q.byte_res == s_q.word[15:8])
        else $error("byte result differs from word top bits");
    a_low_zeros: assert property (
        s_q.word[5:0] == 6'h00)
        else $error("word result low bits not zero");
    a_stop_now: assert property (
        i_bus.wr && i_bus.addr == `OFS_MODE && !i_bus.wdata[7]
        |=> s_q.state == adc_seq_pkg::ST_IDLE && !o_hold && $stable(s_q.word))
        else $error("conversion did not stop on run clear");
    a_chan_restart: assert property (
        chan_write && run_next && s_q.state != adc_seq_pkg::ST_IDLE
        |=> o_sample && s_q.smp_cnt == SAMPLE_TICKS)
        else $error("channel write did not restart sampling");
    a_write_wins: assert property (
        conv_end && cfg_write |=> !o_conversion_done_irq && $stable(s_q.word))
        else $error("config write lost to conversion end");
    a_read_old: assert property (
        i_bus.rd && i_bus.addr == `OFS_RESULT_WORD |=> o_rdata == $past(s_q.word))
        else $error("result read did not return old value");
    a_hold_phase: assert property (
        o_hold |-> !o_sample ##1 (o_hold || o_sample || !run_next))
        else $error("sample and hold overlap");
    a_continuous: assert property (
        o_conversion_done_irq && s_q.mode[7] && !$past(chan_write)
        |-> o_sample && s_q.smp_cnt == SAMPLE_TICKS)
        else $error("no new conversion after completion");
    a_reset_clear: assert property (
        @(posedge i_clk) disable iff (1'b0)
        i_reset |=> s_q.word == 16'h0000 && s_q.byte_res == 8'h00)
        else $error("reset did not clear results");

endmodule : sar_adc_sequencer

/* File: sar_engine.sv */
/*
 * successive-approximation register: msb first trial and compare.
 * assumes i_comp_above is high when the held input >= the trial tap.
 */
`timescale 1ns/1ps

module sar_engine #(
    parameter int WIDTH = 10
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_begin,
    input  wire logic             i_step,
    input  wire logic             i_comp_above,
    output logic [WIDTH-1:0]      o_trial,
    output logic [WIDTH-1:0]      o_result,
    output logic                  o_done
);

    typedef struct packed {
        logic [WIDTH-1:0] trial;
        logic [WIDTH-1:0] mask;
    } sar_state_t;

    localparam logic [WIDTH-1:0] TOP = {1'b1, {(WIDTH-1){1'b0}}};
    localparam logic [WIDTH-1:0] BOTTOM = {{(WIDTH-1){1'b0}}, 1'b1};

    sar_state_t s_q;
    sar_state_t s_d;
    logic [WIDTH-1:0] kept;

    generate
        if (WIDTH < 2) begin : g_bad_width
            $error("sar_engine needs at least two bits");
        end
    endgenerate

    always_comb begin
        s_d    = s_q;
        kept   = i_comp_above ? s_q.trial : (s_q.trial & ~s_q.mask);
        o_done = i_step && (s_q.mask == BOTTOM);
        if (i_begin) begin
            s_d.trial = TOP;
            s_d.mask  = TOP;
        end else if (i_step && (s_q.mask != '0)) begin
            s_d.mask  = s_q.mask >> 1;
            s_d.trial = kept | (s_q.mask >> 1);
        end
    end

    assign o_trial  = s_q.trial;
    assign o_result = kept;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    a_msb_first: assert property (@(posedge i_clk) disable iff (i_reset)
        i_begin |=> (o_trial == TOP))
        else $error("trial does not start at the msb");

endmodule : sar_engine

/* File: step_divider.sv */
/*
 * step divider: one-cycle tick every (rate+1) << level clocks.
 * assumes a synchronous active high reset.
 */
`timescale 1ns/1ps

module step_divider (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic [2:0] i_rate,
    input  wire logic [1:0] i_level,
    input  wire logic       i_run,
    input  wire logic       i_restart,
    output logic            o_tick
);

    typedef struct packed {
        logic [6:0] cnt;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;
    logic [6:0] period;

    // step tick period from rate and level fields; a conversion takes 14 periods
    assign period = 7'({4'h0, i_rate} + 7'h01) << i_level;

    always_comb begin
        s_d    = s_q;
        o_tick = 1'b0;
        if (i_restart || !i_run) begin
            s_d.cnt = 7'h00;
        end else if (s_q.cnt == period - 7'h01) begin
            s_d.cnt = 7'h00;
            o_tick  = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 7'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : step_divider

/* File: testbench.sv */
/*
 * self-checking bench of the converter sequencer with an analog model.
 * assumes the defines header, package and design files compile first.
 */
`timescale 1ns/1ps
`include "adc_seq_defines.svh"

module testbench;
    logic                  i_clk   = 1'b0;
    logic                  i_reset = 1'b1;
    logic                  slow    = 1'b0;
    adc_seq_pkg::reg_req_t bus     = '0;
    logic                  hld_q   = 1'b0;
    logic                  above;
    logic [15:0]           rdata;
    logic                  irq;
    logic                  comp_en;
    logic                  smp;
    logic                  hld;
    logic [3:0]            chan;
    logic [9:0]            tap;
    logic [15:0]           v;
    logic [7:0]            modes [3] = '{8'h81, 8'h93, 8'hBF};
    int                    pers [3]  = '{1, 6, 64};
    int                    codes[$]  = '{0, 1023, 512, 511};
    int                    errors     = 0;
    int                    num_checks = 0;
    int                    cyc        = 0;
    int                    irq_cnt    = 0;
    int                    t0, t1, t2, w, n;

    sar_adc_sequencer i_sar_adc_sequencer (
        .i_clk                 (i_clk),
        .i_reset               (i_reset),
        .i_bus                 (bus),
        .i_comp_above          (above),
        .o_rdata               (rdata),
        .o_conversion_done_irq (irq),
        .o_comparator_enable   (comp_en),
        .o_sample              (smp),
        .o_hold                (hld),
        .o_channel             (chan),
        .o_tap_code            (tap)
    );

    adc_analog_model partner (
        .i_clk      (i_clk),
        .i_enable   (comp_en),
        .i_sample   (smp),
        .i_hold     (hld),
        .i_channel  (chan),
        .i_tap_code (tap),
        .i_slow     (slow),
        .o_above    (above)
    );

    always #5 i_clk = ~i_clk;

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: %h not %h", $time, what, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= d;
        @(posedge i_clk);
        bus.wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
        @(posedge i_clk);
    endtask : rd_reg

    task automatic to_edge(input int e);
        for (int k = 0; k < 5000 && cyc < e; k++) begin
            @(posedge i_clk);
        end
        if (cyc < e) begin
            errors++;
            $display("[FAIL] %0t edge %0d not reached", $time, e);
            report_and_stop();
        end
    endtask : to_edge

    task automatic wait_irq(output int t);
        t = -1;
        for (int k = 0; k < 4000 && t < 0; k++) begin
            @(posedge i_clk);
            if (irq === 1'b1) begin
                t = cyc;
            end
        end
        if (t < 0) begin
            errors++;
            $display("[FAIL] %0t no completion pulse", $time);
            report_and_stop();
        end
    endtask : wait_irq

    task automatic check_result(input int c);
        logic [15:0] r;
        rd_reg(`OFS_RESULT_WORD, r);
        check(r, 16'(c * 64), "word");
        rd_reg(`OFS_RESULT_BYTE, r);
        check(r, 16'(c / 4), "byte");
    endtask : check_result

    always @(posedge i_clk) begin
        cyc   <= cyc + 1;
        hld_q <= hld;
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
        if (smp === 1'b1 && hld === 1'b1) begin
            check(16'h0001, 16'h0000, "sample with hold");
        end
        if (hld === 1'b1 && hld_q !== 1'b1) begin
            check(16'(tap), 16'h0200, "first tap");
        end
    end

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(77));
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        rd_reg(`OFS_RESULT_WORD, v);
        check(v, `RESULT_WORD_RST, "word reset");
        rd_reg(`OFS_RESULT_BYTE, v);
        check(v, 16'(`RESULT_BYTE_RST), "byte reset");
        wr_reg(`OFS_RESULT_WORD, 16'hFFFF);
        rd_reg(`OFS_RESULT_WORD, v);
        check(v, 16'h0000, "word write ignored");
        rd_reg(3'h6, v);
        check(v, 16'h0000, "unmapped read");
        wr_reg(`OFS_MODE, 16'h0041);
        rd_reg(`OFS_MODE, v);
        check(v, 16'h0001, "mode readback");
        check(16'(comp_en), 16'h0001, "comparator on");
        wr_reg(`OFS_PIN_FUNC, 16'h00A5);
        rd_reg(`OFS_PIN_FUNC, v);
        check(v, 16'h0005, "pin function readback");
        repeat (100) @(posedge i_clk);
        rd_reg(`OFS_STATUS, v);
        check(v, 16'h0002, "settled and idle");
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            partner.volt[i]     = $urandom % 1024;
            partner.volt[i + 4] = $urandom % 1024;
            wr_reg(`OFS_CHANNEL, 16'(i));
            wr_reg(`OFS_MODE, 16'(modes[i]));
            wait_irq(t0);
            wait_irq(t1);
            check_result(partner.volt[i]);
            wait_irq(t2);
            check(16'(t2 - t1), 16'(14 * pers[i]), "period");
            to_edge(t2 + 2);
            w = cyc + 1;
            wr_reg(`OFS_CHANNEL, 16'(i + 4));
            wait_irq(t0);
            check(16'(t0 - w), 16'(14 * pers[i] + 1), "restart");
            check_result(partner.volt[i + 4]);
            $display("test timing %0d done", i);
        end
        wr_reg(`OFS_MODE, 16'h0099);
        for (int ch = 0; ch < 12; ch++) begin
            slow <= (ch >= 6);
            partner.volt[ch] = (ch < 4) ? codes[ch] : $urandom % 1024;
            wr_reg(`OFS_CHANNEL, 16'(ch));
            wait_irq(t0);
            check(16'(chan), 16'(ch), "channel");
            check_result(partner.volt[ch]);
        end
        $display("test channels done");
        slow <= 1'b0;
        wr_reg(`OFS_MODE, 16'h0081);
        wait_irq(t0);
        wait_irq(t1);
        n = partner.volt[11];
        partner.volt[11] = 1023 - n;
        to_edge(t1 + 12);
        rd_reg(`OFS_RESULT_WORD, v);
        check(v, 16'(n * 64), "read at end");
        partner.volt[11] = n;
        rd_reg(`OFS_RESULT_WORD, v);
        check(v, 16'((1023 - n) * 64), "after end");
        to_edge(t1 + 26);
        w = irq_cnt;
        wr_reg(`OFS_PIN_FUNC, 16'h0000);
        repeat (3) @(posedge i_clk);
        check(16'(irq_cnt - w), 16'h0000, "pulse on write");
        rd_reg(`OFS_RESULT_WORD, v);
        check(v, 16'((1023 - n) * 64), "store on write");
        wait_irq(t2);
        check(16'(t2 - t1), 16'h002A, "end after write");
        check_result(n);
        $display("test conflicts done");
        wait_irq(t0);
        to_edge(t0 + 5);
        w = irq_cnt;
        wr_reg(`OFS_MODE, 16'h0001);
        repeat (40) @(posedge i_clk);
        check(16'(irq_cnt - w), 16'h0000, "pulse after stop");
        check(16'({smp, hld}), 16'h0000, "busy after stop");
        rd_reg(`OFS_STATUS, v);
        check(v, 16'h0002, "status after stop");
        check_result(n);
        wr_reg(`OFS_MODE, 16'h0000);
        check(16'(comp_en), 16'h0000, "comparator off");
        $display("test stop done");
        wr_reg(`OFS_MODE, 16'h0001);
        repeat (100) @(posedge i_clk);
        wr_reg(`OFS_MODE, 16'h0081);
        rd_reg(`OFS_STATUS, v);
        check(v, 16'h0003, "busy and settled");
        wait_irq(t0);
        repeat (7) @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        check(16'({comp_en, smp, hld}), 16'h0000, "outputs after reset");
        check_result(0);
        $display("test reset done");
        report_and_stop();
    end
endmodule : testbench
